// ### src/rsp_serial_port.sv
// Purpose: serial slave port of a real-time clock (four-wire or three-wire)
// Assumes: link pins oversampled by I_REF_CLK, link clock at most 2.5 MHz
// Notes:   read data must answer within two clocks of each read request
// Summary of operation
// - strap high selects four-wire mode, strap low selects three-wire mode
// - chip enable rising starts a transfer, falling ends it
// - clock level seen when chip enable rises is the idle polarity
// - four-wire: capture on strobe edge, change output on shift edge
// - four-wire: address and data move in bytes, most significant bit first
// - address top bit clear selects reads, set selects writes
// - writes take bytes from serial input, reads drive serial output
// - pointer increments after every data byte while chip enable holds
// - clock region wraps 1Fh to 00h on reads, 9Fh to 80h on writes
// - RAM region wraps 7Fh to 20h on reads, FFh to A0h on writes
// - three-wire: serial input and output share one data line
// - three-wire: bytes move least significant bit first
// - three-wire: capture on rising edge, output on falling edge
// - write protect blocks every register and RAM write
`timescale 1ns/100ps
module rsp_serial_port (
	// clock and reset
	input  wire logic            I_REF_CLK,
	input  wire logic            I_RST,
	// serial link
	input  wire logic            I_CE,
	input  wire logic            I_SCLK,
	input  wire logic            I_SERIAL_IN,
	output logic                 O_SERIAL_OUT,
	output logic                 O_SERIAL_OUT_OE,
	// strap and protection
	input  wire logic            I_INTERFACE_SELECT,
	input  wire logic            I_WRITE_PROTECT,
	// read side
	output logic                 O_RD_REQ,
	output logic           [7:0] O_RD_ADDR,
	input  wire logic            I_RD_VALID,
	input  wire logic      [7:0] I_RD_DATA,
	// write side
	output logic                 O_WR_VALID,
	output rsp_pkg::rsp_wr_s     O_WR,
	input  wire logic            I_WR_READY,
	output logic                 O_WR_DROP
);
	import rsp_pkg::*;

	// ------------------------------------------------------------
	// address pointer step with region wrap
	// ------------------------------------------------------------
	function automatic logic [7:0] step_addr(input logic [7:0] a);
		logic [7:0] r;
		r = a + 8'h01;
		if (a[6:5] == CLK_REGION) begin
			if (a[4:0] == CLK_LAST) begin
				r = {a[7:5], CLK_FIRST};
			end
		end else begin
			if (a[6:0] == RAM_LAST) begin
				r = {a[7], RAM_FIRST};
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic              ce_s;
	logic              sclk_s;
	logic              si_s;
	logic              mode_s;
	logic              wp_s;
	logic              ce_d;
	logic              sclk_d;

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {I_CE, I_SCLK, I_SERIAL_IN, I_INTERFACE_SELECT, I_WRITE_PROTECT};
			sync_b <= sync_a;
		end
	end

	assign {ce_s, sclk_s, si_s, mode_s, wp_s} = sync_b;

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			ce_d   <= 1'b0;
			sclk_d <= 1'b0;
		end else begin
			ce_d   <= ce_s;
			sclk_d <= sclk_s;
		end
	end

	// ------------------------------------------------------------
	// framing, polarity and mode
	// ------------------------------------------------------------
	rsp_state_e state;
	logic       cpol;
	logic       spi_mode;
	logic       ce_rise;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       strobe;
	logic       shift;
	logic [2:0] bit_cnt;
	logic       byte_done;
	logic [7:0] rx;
	logic [7:0] next_rx;
	logic [7:0] ptr;
	logic       is_write;

	assign ce_rise   = ce_s & ~ce_d;
	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;
	assign is_write  = ptr[RW_POS];

	always_comb begin
		if (spi_mode) begin
			// strobe on return to idle, shift on leaving idle
			strobe = cpol ? sclk_rise : sclk_fall;
			shift  = cpol ? sclk_fall : sclk_rise;
		end else begin
			strobe = sclk_rise;
			shift  = sclk_fall;
		end
	end

	assign byte_done = strobe & (state != ST_IDLE) & (bit_cnt == LAST_BIT);

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			cpol     <= 1'b0;
			spi_mode <= 1'b1;
		end else if (ce_rise) begin
			// idle polarity from clock level at enable
			cpol     <= sclk_s;
			// strap caught at start of every frame
			spi_mode <= mode_s;
		end
	end

	// frame start and end follow chip enable
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			state <= ST_IDLE;
		end else if (!ce_s) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (ce_rise) begin
						state <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					// first byte of a frame is the address
					if (byte_done) begin
						state <= ST_DATA;
					end
				end
				ST_DATA: begin
					state <= ST_DATA;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// receive shifter
	// ------------------------------------------------------------
	always_comb begin
		if (spi_mode) begin
			next_rx = {rx[6:0], si_s};
		end else begin
			next_rx = {si_s, rx[7:1]};
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			bit_cnt <= '0;
			rx      <= RST_BYTE;
		end else if (state == ST_IDLE) begin
			bit_cnt <= '0;
		end else if (strobe) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx      <= next_rx;
		end
	end

	// ------------------------------------------------------------
	// address pointer and read requests
	// ------------------------------------------------------------
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			ptr      <= RST_BYTE;
			O_RD_REQ <= 1'b0;
		end else begin
			O_RD_REQ <= 1'b0;
			if (byte_done && state == ST_ADDR) begin
				ptr <= next_rx;
				// top bit clear opens a read
				O_RD_REQ <= ~next_rx[RW_POS];
			end else if (byte_done && state == ST_DATA) begin
				ptr      <= step_addr(ptr);
				O_RD_REQ <= ~is_write;
			end
		end
	end

	assign O_RD_ADDR = ptr;

	// ------------------------------------------------------------
	// transmit shifter and output enable
	// ------------------------------------------------------------
	logic [7:0] tx;
	logic       rd_phase;

	assign rd_phase = (state == ST_DATA) & ~is_write;

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			tx           <= RST_BYTE;
			O_SERIAL_OUT <= RST_OUT;
		end else if (rd_phase && I_RD_VALID) begin
			tx <= I_RD_DATA;
		end else if (rd_phase && shift) begin
			// read data driven onto serial output
			if (spi_mode) begin
				O_SERIAL_OUT <= tx[7];
				tx           <= {tx[6:0], 1'b0};
			end else begin
				O_SERIAL_OUT <= tx[0];
				tx           <= {1'b0, tx[7:1]};
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			O_SERIAL_OUT_OE <= 1'b0;
		end else if (!rd_phase || !ce_s) begin
			O_SERIAL_OUT_OE <= 1'b0;
		end else if (shift) begin
			// shared line is driven only for read bits
			O_SERIAL_OUT_OE <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// write path into the buffer
	// ------------------------------------------------------------
	rsp_wr_s wr_in;
	logic    wr_push;
	logic    wr_ready;

	// protected writes never reach the buffer
	assign wr_push    = byte_done & (state == ST_DATA) & is_write & ~wp_s;
	assign wr_in.addr = ptr;
	assign wr_in.data = next_rx;

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			O_WR_DROP <= 1'b0;
		end else begin
			O_WR_DROP <= wr_push & ~wr_ready;
		end
	end

	rsp_fifo #(
		.WIDTH ($bits(rsp_wr_s)),
		.DEPTH (WR_DEPTH)
	) u_wr_fifo (
		.i_clk       (I_REF_CLK),
		.i_rst       (I_RST),
		.i_in_valid  (wr_push),
		.o_in_ready  (wr_ready),
		.i_in_data   (wr_in),
		.o_out_valid (O_WR_VALID),
		.i_out_ready (I_WR_READY),
		.o_out_data  (O_WR)
	);

endmodule // rsp_serial_port

// ### src/rsp_pkg.sv
// Purpose: shared constants and types of the serial slave port
// Assumes: byte-wide clock register and user RAM address space
// Notes:   address bit 7 selects a write, clear selects a read
package rsp_pkg;

	// ------------------------------------------------------------
	// byte framing
	// ------------------------------------------------------------
	localparam int unsigned BYTE_W   = 8;
	localparam logic [2:0]  LAST_BIT = 3'h7;
	localparam int unsigned RW_POS   = 7;

	// ------------------------------------------------------------
	// address map and burst wrap points
	// ------------------------------------------------------------
	localparam logic [6:0] RAM_FIRST  = 7'h20;
	localparam logic [6:0] RAM_LAST   = 7'h7f;
	localparam logic [1:0] CLK_REGION = 2'h0;
	localparam logic [4:0] CLK_LAST   = 5'h1f;
	localparam logic [4:0] CLK_FIRST  = 5'h00;

	// ------------------------------------------------------------
	// write buffer and reset values
	// ------------------------------------------------------------
	localparam int unsigned WR_DEPTH   = 8;
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic        RST_OUT    = 1'h0;
	localparam int unsigned SYNC_W     = 5;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rsp_wr_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA
	} rsp_state_e;

endpackage

// ### src/rsp_fifo.sv
// Purpose: write buffer between the serial port and the register/RAM side
// Assumes: one clock, synchronous active-high reset
// Notes:   push is ignored while full, pop is ignored while empty
`timescale 1ns/100ps
module rsp_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// filling side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// draining side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;
	assign o_out_data  = mem[rd_ptr];

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	// ------------------------------------------------------------
	// pointers and fill level
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule // rsp_fifo

// ### bench/rsp_serial_port_checker.sv
// Purpose: pin-level assertions for the serial slave port
// Assumes: link half period of four or more reference clocks
// Notes:   pointer steps judged only well after chip enable rises
`timescale 1ns/100ps
module rsp_serial_port_checker (
	// clock and reset
	input wire logic             I_REF_CLK,
	input wire logic             I_RST,
	// link and protection
	input wire logic             I_CE,
	input wire logic             I_SCLK,
	input wire logic             O_SERIAL_OUT,
	input wire logic             O_SERIAL_OUT_OE,
	input wire logic             I_WRITE_PROTECT,
	// read and write side
	input wire logic             O_RD_REQ,
	input wire logic       [7:0] O_RD_ADDR,
	input wire logic             O_WR_VALID,
	input wire rsp_pkg::rsp_wr_s O_WR,
	input wire logic             O_WR_DROP
);
	import rsp_pkg::*;
	logic [7:0] ce_run;
	// --------
	// cycles since chip enable rose
	// --------
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST || !I_CE)
			ce_run <= 8'h00;
		else if (ce_run != 8'hff)
			ce_run <= ce_run + 8'h01;
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);
	sequence s_step;
		$changed(O_RD_ADDR) && ce_run > 8'h64;
	endsequence
	sequence s_wrap(logic [6:0] lo);
		s_step ##0 $past(O_RD_ADDR[6:0]) == lo;
	endsequence
	AST_STEP: assert property (s_step ##0 !($past(O_RD_ADDR[6:0]) inside {7'h1f, 7'h7f})
		|-> O_RD_ADDR == $past(O_RD_ADDR) + 8'h01)
		else $error("pointer did not step by one");
	AST_WRAP_CLK: assert property (s_wrap(7'h1f) |-> O_RD_ADDR == {$past(O_RD_ADDR[7]), 7'h00})
		else $error("clock region wrap wrong");
	AST_WRAP_RAM: assert property (s_wrap(7'h7f) |-> O_RD_ADDR == {$past(O_RD_ADDR[7]), 7'h20})
		else $error("ram region wrap wrong");
	AST_RD_SPACE: assert property (O_RD_REQ |-> !O_RD_ADDR[7])
		else $error("read request on write address");
	AST_WR_SPACE: assert property (O_WR_VALID |-> O_WR.addr[7])
		else $error("write entry on read address");
	AST_IDLE: assert property (!I_CE [*6] |-> !O_RD_REQ && !O_WR_DROP)
		else $error("activity outside a frame");
	AST_RELEASE: assert property ($fell(I_CE) |-> ##[1:5] !O_SERIAL_OUT_OE)
		else $error("output not released after frame");
	AST_OE_READ: assert property (O_RD_REQ |-> ##[1:16] O_SERIAL_OUT_OE)
		else $error("read data never driven");
	AST_WP: assert property (I_WRITE_PROTECT [*6] |-> !$rose(O_WR_VALID))
		else $error("write passed while protected");
	AST_OUT_EDGE: assert property (O_SERIAL_OUT_OE && $changed(O_SERIAL_OUT)
		|-> $past(I_SCLK, 2) != $past(I_SCLK, 6))
		else $error("output changed without a link edge");
endmodule // rsp_serial_port_checker

bind rsp_serial_port rsp_serial_port_checker rsp_serial_port_checker_inst (
	.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_SCLK(I_SCLK),
	.O_SERIAL_OUT(O_SERIAL_OUT), .O_SERIAL_OUT_OE(O_SERIAL_OUT_OE),
	.I_WRITE_PROTECT(I_WRITE_PROTECT), .O_RD_REQ(O_RD_REQ), .O_RD_ADDR(O_RD_ADDR),
	.O_WR_VALID(O_WR_VALID), .O_WR(O_WR), .O_WR_DROP(O_WR_DROP));

// ### bench/rsp_master_model.sv
// Purpose: serial bus master driving the port
// Assumes: half period 200 ns, shift edge then strobe edge
// Notes:   read bytes land in dat
`timescale 1ns/100ps
module rsp_master_model (
	// link
	output logic      o_ce,
	output logic      o_sclk,
	output logic      o_bit,
	input  wire logic i_din
);
	logic [7:0] dat [16];
	initial begin
		o_ce = 1'h0;
		o_sclk = 1'h0;
		o_bit = 1'h0;
	end
	// --------
	// one bit per link clock
	// --------
	task automatic bit_x(input logic w3, p, rd, input int i, inout logic [7:0] v);
		o_sclk = w3 ? 1'h0 : ~p;
		o_bit = rd ? ~o_bit : v[i];
		#200 o_sclk = ~o_sclk;
		#100 if (rd) v[i] = i_din;
		#100;
	endtask
	task automatic xfer(input logic w3, p, input logic [7:0] a, input int n);
		logic [7:0] av;
		av = a;
		#13 o_sclk = p;
		#300 o_ce = 1'h1;
		#300;
		for (int i = 0; i < 8; i++) bit_x(w3, p, 1'h0, w3 ? i : 7 - i, av);
		for (int k = 0; k < n; k++)
			for (int i = 0; i < 8; i++) bit_x(w3, p, !a[7], w3 ? i : 7 - i, dat[k]);
		#300 o_sclk = p;
		#300 o_ce = 1'h0;
		#500;
	endtask
endmodule // rsp_master_model

// ### bench/tb_rsp_serial_port.sv
// Purpose: self-checking bench of the serial slave port
// Assumes: master model drives the link, bench serves read and write side
// Notes:   random data from a fixed seed
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb_rsp_serial_port;
	import rsp_pkg::*;
	logic       I_REF_CLK = 1'h0;
	logic       I_RST = 1'h1;
	logic       sel = 1'h1;
	logic       wp = 1'h0;
	logic       rd_valid = 1'h0;
	logic [7:0] rd_data = 8'h00;
	logic       wr_ready = 1'h0;
	logic       hold = 1'h0;
	logic       ce, sclk, mbit, sout, oe, rd_req, wr_valid, drop;
	logic [7:0] rd_addr, a;
	rsp_wr_s    wr, got;
	rsp_wr_s    wr_q[$];
	int         fail_count = 0, total_checks = 0, drops = 0, seed = 32'hbb9b712c;
	always #25 I_REF_CLK = ~I_REF_CLK;
	// one shared line in three-wire mode
	wire sin = (!sel && oe) ? sout : mbit;
	wire din = oe ? sout : ~sout;
	rsp_master_model rsp_master_model_inst (.o_ce(ce), .o_sclk(sclk), .o_bit(mbit), .i_din(din));
	rsp_serial_port rsp_serial_port_inst (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_CE(ce),
		.I_SCLK(sclk), .I_SERIAL_IN(sin), .O_SERIAL_OUT(sout), .O_SERIAL_OUT_OE(oe),
		.I_INTERFACE_SELECT(sel), .I_WRITE_PROTECT(wp), .O_RD_REQ(rd_req), .O_RD_ADDR(rd_addr),
		.I_RD_VALID(rd_valid), .I_RD_DATA(rd_data), .O_WR_VALID(wr_valid), .O_WR(wr),
		.I_WR_READY(wr_ready), .O_WR_DROP(drop));
	function automatic logic [7:0] mem(input logic [7:0] x);
		return x ^ 8'h5a;
	endfunction
	function automatic logic [7:0] nxt(input logic [7:0] x);
		case (x)
			8'h1f, 8'h9f: return {x[7], 7'h00};
			8'h7f, 8'hff: return {x[7], 7'h20};
			default: return x + 8'h01;
		endcase
	endfunction
	always @(posedge I_REF_CLK) begin
		rd_valid <= rd_req;
		rd_data <= rd_req ? mem(rd_addr) : 8'($random(seed));
		wr_ready <= !hold && ($random(seed) % 2 != 0);
		if (wr_valid && wr_ready) wr_q.push_back(wr);
		if (drop) drops++;
	end
	task results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task run(input logic w3, p, input logic [7:0] st, input int n, ne);
		int t;
		logic [7:0] x;
		t = 0;
		x = st;
		@(posedge I_REF_CLK);
		sel <= !w3;
		for (int k = 0; k < 16; k++) rsp_master_model_inst.dat[k] = 8'($random(seed));
		rsp_master_model_inst.xfer(w3, p, st, n);
		hold <= 1'h0;
		while (st[7] && wr_q.size() < ne && t < 400) begin
			@(posedge I_REF_CLK);
			t++;
		end
		if (t == 400) begin
			fail_count++;
			results();
		end
		for (int k = 0; k < ne; k++) begin
			if (st[7]) begin
				got = wr_q.pop_front();
				`CHK(got, {x, rsp_master_model_inst.dat[k]})
			end else `CHK(rsp_master_model_inst.dat[k], mem(x))
			x = nxt(x);
		end
	endtask
	initial begin
		repeat (4) @(posedge I_REF_CLK);
		I_RST <= 1'h0;
		repeat (3) @(posedge I_REF_CLK);
		for (int m = 0; m < 4; m++) begin
			a = 8'($random(seed)) | 8'ha0;
			run(m[1], m[0], m == 0 ? 8'h9e : m == 1 ? 8'hfe : a, 3, 3);
			run(m[1], m[0], m == 0 ? 8'h1e : m == 1 ? 8'h7e : a & 8'h7f, 3, 3);
			$display("mode %0d done", m);
		end
		run(1'h0, 1'h0, 8'h05, 1, 1);
		wp <= 1'h1;
		run(1'h0, 1'h1, 8'h85, 1, 0);
		`CHK(wr_q.size(), 0)
		$display("protect done");
		wp <= 1'h0;
		hold <= 1'h1;
		drops = 0;
		run(1'h0, 1'h0, 8'ha0, 10, 8);
		`CHK(drops, 2)
		$display("fill done");
		results();
	end
	initial begin
		#2000000;
		fail_count++;
		results();
	end
endmodule // tb_rsp_serial_port
